// ===== bms_cfg.svh
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH
// Clock rate used to turn times into cycle counts.
`define BMS_CLK_MHZ 10
`define BMS_CYC_US(t) ((t) * `BMS_CLK_MHZ)
`define BMS_CYC_MS(t) ((t) * 1000 * `BMS_CLK_MHZ)
`define BMS_CYC_S(t) ((t) * 1000000 * `BMS_CLK_MHZ)
// Register byte offsets.
`define BMS_OFS_CTRL 12'h000
`define BMS_OFS_STAT 12'h004
// Control register fields.
`define BMS_CTRL_STORE 0
`define BMS_CTRL_HIZ 1
`define BMS_CTRL_RECOV 2
`define BMS_CTRL_CHGDIS 3
`define BMS_CTRL_LDO 4
`define BMS_CTRL_MONREQ 5
`define BMS_CTRL_RESET 5'h00
// Status register fields.
`define BMS_STAT_STATE 0
`define BMS_STAT_BUSOFF 4
`define BMS_STAT_HOSTUP 5
`define BMS_STAT_MONBUSY 6
`define BMS_STAT_BATOK 7
`define BMS_STAT_MONCODE 8
`define BMS_STAT_SCOFF 13
// Synchroniser reset image: button released, charge-disable low.
`define BMS_SYNC_RESET 16'h0002
// Times in their own units.
`define BMS_FIRST_WAKE_TIME_MS 80
`define BMS_T_QUIET_MS 1
`define BMS_SHORT_DEGLITCH_TIME_US 250
`define BMS_SHORT_RECOVERY_TIME_S 2
`define BMS_T_LONG_S 5
`define BMS_T_MON_MS 2
`define BMS_T_HOST_MS 5
`define BMS_T_BAT_DGL_US 100
// Highest monitor step: 60 % plus 20 steps of 2 % reaches 100 %.
`define BMS_MON_STEPS 5'h14
`endif

// ===== bms_pkg.sv
`default_nettype none
package bms_pkg;
  typedef enum logic [3:0] {
    ST_STORAGE = 4'b0001,
    ST_HIZ = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_INPUT = 4'b1000
  } bms_state_e;
  typedef logic [4:0] bms_code_t;
endpackage
`default_nettype wire

// ===== bms_sequencer.sv
// Implementation choices: the register offsets and the APB slave port.
`include "bms_cfg.svh"
`default_nettype none
module bms_sequencer #(
  parameter int WAKE1_CYC = `BMS_CYC_MS(`BMS_FIRST_WAKE_TIME_MS),
  parameter int QUIET_CYC = `BMS_CYC_MS(`BMS_T_QUIET_MS),
  parameter int REC_SC_CYC = `BMS_CYC_S(`BMS_SHORT_RECOVERY_TIME_S),
  parameter int LONG_CYC = `BMS_CYC_S(`BMS_T_LONG_S),
  parameter int MON_CYC = `BMS_CYC_MS(`BMS_T_MON_MS),
  parameter int HOST_CYC = `BMS_CYC_MS(`BMS_T_HOST_MS)
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input wire logic charge_disable_pin,
  input wire logic push_button_n,
  input wire logic load_switch_control_input,
  // Analog comparators.
  input wire logic vin_valid,
  input wire logic vin_above_sleep,
  input wire logic bat_above_hyst,
  input wire logic bat_below_uvlo,
  input wire logic bat_above_max_uvlo,
  input wire logic bat_above_min_uvlo,
  input wire logic short_limit,
  input wire logic sys_in_regulation,
  input wire logic [4:0] monitor_code,
  // Power stage controls, host readiness and state.
  output logic battery_switch_on,
  output logic supplement_on,
  output logic sys_enable,
  output logic charge_enable,
  output logic ldo_enable,
  output logic inter_node_power_on,
  output logic inter_node_pulldown_on,
  output logic monitor_load_on,
  output logic host_if_active,
  output bms_pkg::bms_state_e state
);
  import bms_pkg::*;

  localparam int CW = 27;
  localparam int DGL_SC_CYC = `BMS_CYC_US(`BMS_SHORT_DEGLITCH_TIME_US);
  localparam int BAT_DGL_CYC = `BMS_CYC_US(`BMS_T_BAT_DGL_US);

  // Saturating counter step, cleared whenever its run condition drops.
  function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c, input logic run,
                                             input int lim);
    if (!run) begin
      cnt_step = '0;
    end else if (c >= CW'(lim)) begin
      cnt_step = c;
    end else begin
      cnt_step = c + 1'b1;
    end
  endfunction

  function automatic logic cnt_done(input logic [CW-1:0] c, input int lim);
    cnt_done = (c >= CW'(lim));
  endfunction

  logic [15:0] sync1_q, sync2_q;
  bms_code_t mon_code_s;
  logic vin_ok_s, vin_sleep_s, bat_hyst_s, bat_below_s, bat_max_s, bat_min_s;
  logic short_s, sys_reg_s, chgdis_s, button_n_s, lsw_s;
  bms_state_e state_q, state_d;
  logic st_store, st_hiz, st_act, st_in;
  logic [4:0] ctrl_q;
  logic chgdis_prev_q, vin_prev_q, bus_off_q, long_armed_q, wake_held_q;
  logic sc_off_q, bat_ok_q, mon_busy_q;
  logic [CW-1:0] wake_cnt_q, quiet_cnt_q, long_cnt_q, sc_cnt_q, bat_cnt_q;
  logic [CW-1:0] mon_cnt_q, host_cnt_q;
  bms_code_t mon_result_q;
  logic [31:0] prdata_q;
  logic access, setup, hit_ctrl, hit_stat, bus_ok, wr_ctrl;
  logic chg_toggle, hiz_want, entry_cond, quiet_done, wake_ok, mon_done, mon_start;
  logic wake_run, bat_sw_req;

  // Every pin and comparator is asynchronous, so all pass two flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= `BMS_SYNC_RESET;
      sync2_q <= `BMS_SYNC_RESET;
    end else begin
      sync1_q <= {monitor_code, vin_valid, vin_above_sleep, bat_above_hyst, bat_below_uvlo,
                  bat_above_max_uvlo, bat_above_min_uvlo, short_limit, sys_in_regulation,
                  charge_disable_pin, push_button_n, load_switch_control_input};
      sync2_q <= sync1_q;
    end
  end

  assign {mon_code_s, vin_ok_s, vin_sleep_s, bat_hyst_s, bat_below_s, bat_max_s, bat_min_s,
          short_s, sys_reg_s, chgdis_s, button_n_s, lsw_s} = sync2_q;

  assign st_store = (state_q == ST_STORAGE);
  assign st_hiz = (state_q == ST_HIZ);
  assign st_act = (state_q == ST_ACTIVE);
  assign st_in = (state_q == ST_INPUT);
  assign state = state_q;

  // Bus decode; the slave answers in the access phase with no wait states.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = (paddr == `BMS_OFS_CTRL);
  assign hit_stat = (paddr == `BMS_OFS_STAT);
  assign bus_ok = host_if_active & ~bus_off_q & ~st_store;
  assign wr_ctrl = access & pwrite & bus_ok & hit_ctrl & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access & (~bus_ok | ~(hit_ctrl | hit_stat) | (pwrite & hit_stat));
  assign prdata = prdata_q;
  assign chg_toggle = (chgdis_s != chgdis_prev_q);

  // Read data is captured in the setup cycle so that it comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      if (bus_ok && hit_ctrl) begin
        prdata_q[4:0] <= ctrl_q;
        prdata_q[`BMS_CTRL_MONREQ] <= mon_busy_q;
      end else if (bus_ok && hit_stat) begin
        prdata_q[`BMS_STAT_STATE +: 4] <= state_q;
        prdata_q[`BMS_STAT_BUSOFF] <= bus_off_q;
        prdata_q[`BMS_STAT_HOSTUP] <= host_if_active;
        prdata_q[`BMS_STAT_MONBUSY] <= mon_busy_q;
        prdata_q[`BMS_STAT_BATOK] <= bat_ok_q;
        prdata_q[`BMS_STAT_MONCODE +: 5] <= mon_result_q;
        prdata_q[`BMS_STAT_SCOFF] <= sc_off_q;
      end
    end
  end

  // Control bits. A write clears the storage request only while input is valid; entering storage also clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BMS_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[`BMS_CTRL_RECOV] <= pwdata[`BMS_CTRL_RECOV];
        ctrl_q[`BMS_CTRL_CHGDIS] <= pwdata[`BMS_CTRL_CHGDIS];
        ctrl_q[`BMS_CTRL_LDO] <= pwdata[`BMS_CTRL_LDO];
      end
      if (state_d == ST_STORAGE && !st_store) begin
        ctrl_q[`BMS_CTRL_STORE] <= 1'b0;
      end else if (wr_ctrl && (pwdata[`BMS_CTRL_STORE] || vin_ok_s)) begin
        ctrl_q[`BMS_CTRL_STORE] <= pwdata[`BMS_CTRL_STORE];
      end
      // A pin toggle releases a pending high-impedance request.
      if (wr_ctrl) begin
        ctrl_q[`BMS_CTRL_HIZ] <= pwdata[`BMS_CTRL_HIZ];
      end else if (chg_toggle) begin
        ctrl_q[`BMS_CTRL_HIZ] <= 1'b0;
      end
    end
  end

  // Bus lock-out after a battery-only high-impedance write; a new write cannot arrive
  // while locked, so the pin toggle is the only way out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_off_q <= 1'b0;
      chgdis_prev_q <= 1'b0;
      vin_prev_q <= 1'b0;
    end else begin
      chgdis_prev_q <= chgdis_s;
      vin_prev_q <= vin_ok_s;
      if (wr_ctrl && pwdata[`BMS_CTRL_HIZ] && !vin_ok_s) begin
        bus_off_q <= 1'b1;
      end else if (chg_toggle) begin
        bus_off_q <= 1'b0;
      end
    end
  end

  assign hiz_want = ~chgdis_s | ctrl_q[`BMS_CTRL_HIZ];
  assign entry_cond = st_act & ~vin_ok_s & chgdis_s & button_n_s &
                      (ctrl_q[`BMS_CTRL_STORE] | long_armed_q);
  assign quiet_done = entry_cond & cnt_done(quiet_cnt_q, QUIET_CYC);
  assign wake_ok = wake_held_q & button_n_s;
  assign wake_run = (st_store & ~button_n_s & bat_max_s) |
                    (vin_ok_s & ~button_n_s & long_armed_q);
  assign mon_done = mon_busy_q & cnt_done(mon_cnt_q, MON_CYC);
  assign mon_start = ~mon_busy_q & ((wr_ctrl & pwdata[`BMS_CTRL_MONREQ]) |
                                    (st_act & hiz_want & ~vin_ok_s));

  // State selection; high-impedance is reached only through active battery.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STORAGE: begin
        if (vin_sleep_s) begin
          state_d = ST_INPUT;
        end else if (wake_ok) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_INPUT: begin
        if (!vin_ok_s) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (vin_ok_s) begin
          state_d = ST_INPUT;
        end else if (quiet_done) begin
          state_d = ST_STORAGE;
        end else if (hiz_want && mon_done) begin
          state_d = ST_HIZ;
        end
      end
      ST_HIZ: begin
        if (vin_ok_s) begin
          state_d = ST_INPUT;
        end else if (!hiz_want) begin
          state_d = ST_ACTIVE;
        end
      end
      default: state_d = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // Timers for quiet period, wake press, long press and host readiness.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt_q <= '0;
      wake_cnt_q <= '0;
      long_cnt_q <= '0;
      host_cnt_q <= '0;
    end else begin
      quiet_cnt_q <= cnt_step(quiet_cnt_q, entry_cond, QUIET_CYC);
      wake_cnt_q <= cnt_step(wake_cnt_q, wake_run, WAKE1_CYC);
      long_cnt_q <= cnt_step(long_cnt_q, ~button_n_s & ~st_store, LONG_CYC);
      host_cnt_q <= cnt_step(host_cnt_q, sys_reg_s & ~st_store, HOST_CYC);
    end
  end

  // Long-press arming and the adapter exception that keeps it pending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_armed_q <= 1'b0;
      wake_held_q <= 1'b0;
    end else begin
      if (st_store || (state_d == ST_STORAGE)) begin
        long_armed_q <= 1'b0;
      end else if (vin_ok_s && !vin_prev_q && button_n_s) begin
        long_armed_q <= 1'b0;
      end else if (vin_ok_s && cnt_done(wake_cnt_q, WAKE1_CYC)) begin
        long_armed_q <= 1'b0;
      end else if (!vin_ok_s && !ctrl_q[`BMS_CTRL_RECOV] && cnt_done(long_cnt_q, LONG_CYC)) begin
        long_armed_q <= 1'b1;
      end
      if (!st_store) begin
        wake_held_q <= 1'b0;
      end else if (st_store && cnt_done(wake_cnt_q, WAKE1_CYC)) begin
        wake_held_q <= 1'b1;
      end
    end
  end

  // Battery threshold with hysteresis, then deglitch before the system rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bat_ok_q <= 1'b0;
      bat_cnt_q <= '0;
    end else begin
      if (bat_below_s) begin
        bat_ok_q <= 1'b0;
      end else if (bat_hyst_s) begin
        bat_ok_q <= 1'b1;
      end
      bat_cnt_q <= cnt_step(bat_cnt_q, bat_ok_q & (st_act | st_hiz), BAT_DGL_CYC);
    end
  end

  assign bat_sw_req = (bat_ok_q & (st_act | st_hiz)) | (st_in & bat_min_s);

  // Short retry: deglitch the limit, hold the switch off, then test again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_off_q <= 1'b0;
      sc_cnt_q <= '0;
    end else if (!sc_off_q) begin
      if (cnt_done(sc_cnt_q, DGL_SC_CYC)) begin
        sc_off_q <= 1'b1;
        sc_cnt_q <= '0;
      end else begin
        sc_cnt_q <= cnt_step(sc_cnt_q, short_s & bat_sw_req, DGL_SC_CYC);
      end
    end else if (cnt_done(sc_cnt_q, REC_SC_CYC)) begin
      sc_off_q <= 1'b0;
      sc_cnt_q <= '0;
    end else begin
      sc_cnt_q <= cnt_step(sc_cnt_q, 1'b1, REC_SC_CYC);
    end
  end

  // Monitor: the divider load stays on until the result is latched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_busy_q <= 1'b0;
      mon_cnt_q <= '0;
      mon_result_q <= 5'h00;
    end else begin
      if (mon_start) begin
        mon_busy_q <= 1'b1;
      end else if (mon_done) begin
        mon_busy_q <= 1'b0;
        mon_result_q <= (mon_code_s > `BMS_MON_STEPS) ? `BMS_MON_STEPS : mon_code_s;
      end
      mon_cnt_q <= cnt_step(mon_cnt_q, mon_busy_q & ~mon_done, MON_CYC);
    end
  end

  // Registered power-stage controls; in storage all is off but the pull-down, a running monitor load and node power while pressed above max UVLO.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_switch_on <= 1'b0;
      supplement_on <= 1'b0;
      sys_enable <= 1'b0;
      charge_enable <= 1'b0;
      ldo_enable <= 1'b0;
      inter_node_power_on <= 1'b0;
      inter_node_pulldown_on <= 1'b0;
      monitor_load_on <= 1'b0;
      host_if_active <= 1'b0;
    end else begin
      battery_switch_on <= bat_sw_req & ~sc_off_q;
      supplement_on <= st_in & bat_min_s;
      sys_enable <= st_in | ((st_act | st_hiz) & cnt_done(bat_cnt_q, BAT_DGL_CYC));
      charge_enable <= st_in & ~chgdis_s & ~ctrl_q[`BMS_CTRL_CHGDIS];
      ldo_enable <= ~st_store & (ctrl_q[`BMS_CTRL_LDO] | lsw_s);
      inter_node_power_on <= ~st_store | (~button_n_s & bat_max_s);
      inter_node_pulldown_on <= st_store;
      monitor_load_on <= mon_busy_q;
      host_if_active <= cnt_done(host_cnt_q, HOST_CYC) & ~st_store;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_onehot; $onehot(state_q); endproperty
  a_onehot: assert property (p_onehot) else $error("state not one-hot");
  property p_store_entry; $rose(st_store) |-> $past(entry_cond) && !$past(vin_ok_s); endproperty
  a_store_entry: assert property (p_store_entry) else $error("bad storage entry");
  property p_store_off; st_store |=> !battery_switch_on && !sys_enable && !host_if_active;
  endproperty
  a_store_off: assert property (p_store_off) else $error("device on in storage");
  property p_pulldown; st_store |=> inter_node_pulldown_on && !ldo_enable; endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down missing");
  property p_wake; $fell(st_store) && !$past(vin_sleep_s) |-> $past(wake_held_q); endproperty
  a_wake: assert property (p_wake) else $error("early wake exit");
  property p_sc_dgl; $rose(sc_off_q) |-> $past(sc_cnt_q) == CW'(DGL_SC_CYC); endproperty
  a_sc_dgl: assert property (p_sc_dgl) else $error("short deglitch wrong");
  property p_sc_off; $rose(sc_off_q) |=> (!battery_switch_on && sc_off_q)[*8]; endproperty
  a_sc_off: assert property (p_sc_off) else $error("switch on during recovery");
  property p_hiz_mon; $rose(st_hiz) |-> $past(mon_busy_q) && !mon_busy_q; endproperty
  a_hiz_mon: assert property (p_hiz_mon) else $error("no reading before hi-z");
  property p_bus_off; access && bus_off_q |-> pslverr ##1 !($changed(ctrl_q)) || chg_toggle;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus used while locked");
  property p_charge; charge_enable |-> $past(st_in) && !$past(chgdis_s); endproperty
  a_charge: assert property (p_charge) else $error("charge while disabled");
  property p_mon_range; mon_result_q <= `BMS_MON_STEPS; endproperty
  a_mon_range: assert property (p_mon_range) else $error("monitor step out of range");
endmodule
`default_nettype wire

// ===== bms_pkg_order_note.sv
`default_nettype none
`default_nettype wire

// ===== bms_stage_model.sv
`default_nettype none
module bms_stage_model (
  // Clock.
  input wire logic pclk,
  // Scenario controls.
  input wire logic vin_on,
  input wire logic bat_low,
  input wire logic short_on,
  input wire logic [4:0] level,
  // Switch states from the sequencer.
  input wire logic battery_switch_on,
  input wire logic supplement_on,
  // Comparator levels.
  output logic vin_valid,
  output logic vin_above_sleep,
  output logic bat_above_hyst,
  output logic bat_below_uvlo,
  output logic bat_above_max_uvlo,
  output logic bat_above_min_uvlo,
  output logic short_limit,
  output logic sys_in_regulation,
  output logic [4:0] monitor_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet levels at time zero, so no unknown reaches the sequencer.
  initial begin
    {vin_valid, vin_above_sleep, bat_below_uvlo, short_limit, sys_in_regulation} = '0;
    {bat_above_hyst, bat_above_max_uvlo, bat_above_min_uvlo} = '1;
    monitor_code = 5'h00;
  end
  // Comparators settle a clock late; a short trips only while a switch conducts.
  always @(posedge pclk) begin
    vin_valid <= vin_on;
    vin_above_sleep <= vin_on;
    bat_above_hyst <= !bat_low;
    bat_below_uvlo <= bat_low;
    bat_above_max_uvlo <= !bat_low;
    bat_above_min_uvlo <= !bat_low;
    short_limit <= short_on && (battery_switch_on || supplement_on);
    sys_in_regulation <= (battery_switch_on || vin_on) && !short_on;
    monitor_code <= level;
  end
endmodule
`default_nettype wire

// ===== bms_sequencer_tb.sv
`include "bms_cfg.svh"
`default_nettype none
module bms_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bms_pkg::*;
  localparam int WAKE1 = 20;
  localparam int QUIET = 8;
  localparam int LONG = 40;
  localparam int MON = 10;
  localparam int REC = 30;
  localparam int DGL = 2500;
  localparam logic [11:0] CTRL = `BMS_OFS_CTRL;
  localparam logic [11:0] STAT = `BMS_OFS_STAT;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic cd_pin = 1'b1; // High keeps battery-only operation active rather than high impedance.
  logic lsw = 1'b0;
  logic button_n = 1'b1;
  logic vin_on = 1'b0;
  logic bat_low = 1'b0;
  logic short_on = 1'b0;
  logic [4:0] level = 5'h00;
  logic vin_valid, vin_above_sleep, bat_above_hyst, bat_below_uvlo;
  logic bat_above_max_uvlo, bat_above_min_uvlo, short_limit, sys_in_regulation;
  logic [4:0] monitor_code;
  logic battery_switch_on, supplement_on, sys_enable, charge_enable, ldo_enable;
  logic inter_node_power_on, inter_node_pulldown_on, monitor_load_on, host_if_active;
  bms_state_e state;
  logic [32:0] exp_q[$];
  logic [32:0] mask_q[$];
  logic [32:0] mon_e, mon_m;
  logic [7:0] rnd = 8'h29;
  int miscompares = 0;
  int n_checks = 0;

  bms_sequencer #(.WAKE1_CYC(WAKE1), .QUIET_CYC(QUIET), .REC_SC_CYC(REC), .LONG_CYC(LONG),
    .MON_CYC(MON), .HOST_CYC(10)) bms_sequencer_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .charge_disable_pin(cd_pin), .push_button_n(button_n),
    .load_switch_control_input(lsw), .vin_valid, .vin_above_sleep, .bat_above_hyst,
    .bat_below_uvlo, .bat_above_max_uvlo, .bat_above_min_uvlo, .short_limit,
    .sys_in_regulation, .monitor_code, .battery_switch_on, .supplement_on, .sys_enable,
    .charge_enable, .ldo_enable, .inter_node_power_on, .inter_node_pulldown_on,
    .monitor_load_on, .host_if_active, .state);
  bms_stage_model bms_stage_model_inst (.pclk, .vin_on, .bat_low, .short_on, .level,
    .battery_switch_on, .supplement_on, .vin_valid, .vin_above_sleep, .bat_above_hyst,
    .bat_below_uvlo, .bat_above_max_uvlo, .bat_above_min_uvlo, .short_limit,
    .sys_in_regulation, .monitor_code);

  // A 100 ns clock.
  always #50 pclk = ~pclk;

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
    n_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One transfer; the note is queued first so the monitor can never miss it.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] expv, input logic [32:0] m);
    exp_q.push_back(expv);
    mask_q.push_back(m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic wait_state(input bms_state_e s, input int lim);
    int i;
    for (i = 0; i < lim && state !== s; i++) @(negedge pclk);
    chk({29'h0, state}, {29'h0, s});
  endtask

  // Host readiness needs the system rail, which can take the battery deglitch.
  task automatic wait_host();
    int i;
    for (i = 0; i < 3000 && host_if_active !== 1'b1; i++) @(negedge pclk);
  endtask

  // Each completed transfer takes the oldest note and compares under its mask.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_m = mask_q.pop_front();
      chk({pslverr, prdata} & mon_m, mon_e & mon_m);
    end
  end

  // A hang counts as a failure.
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    int t;
    cyc(3);
    chk({29'h0, state}, {29'h0, ST_ACTIVE});
    chk({1'b0, prdata}, 33'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_host();
    chk({31'h0, host_if_active, battery_switch_on}, 33'h3);
    rnd = lfsr(rnd);
    apb(0, STAT, 32'h0, 33'h24, 33'h1_0000_003F);
    apb(0, {2'b01, rnd, 2'b00}, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    apb(1, STAT, 32'hFFFF_FFFF, 33'h1_0000_0000, 33'h1_0000_0000);
    // Persistent short: deglitch, off for the recovery time, retry.
    @(posedge pclk);
    short_on <= 1'b1;
    for (t = 0; t < 3000 && battery_switch_on !== 1'b0; t++) @(negedge pclk);
    chk({32'h0, t >= DGL && t <= DGL + 8}, 33'h1);
    for (t = 0; t < 200 && battery_switch_on !== 1'b1; t++) @(negedge pclk);
    chk({32'h0, t >= REC - 1 && t <= REC + 4}, 33'h1);
    for (t = 0; t < 3000 && battery_switch_on !== 1'b0; t++) @(negedge pclk);
    chk({32'h0, battery_switch_on}, 33'h0);
    @(posedge pclk);
    short_on <= 1'b0;
    bat_low <= 1'b1;
    cyc(REC + 8);
    chk({32'h0, battery_switch_on}, 33'h0);
    @(posedge pclk);
    bat_low <= 1'b0;
    for (t = 0; t < 1500 && battery_switch_on !== 1'b1; t++) @(negedge pclk);
    chk({32'h0, battery_switch_on}, 33'h1);
    wait_host();
    @(posedge pclk);
    vin_on <= 1'b1;
    wait_state(ST_INPUT, 20);
    @(posedge pclk);
    cd_pin <= 1'b0;
    cyc(4);
    chk({31'h0, supplement_on, charge_enable}, 33'h3);
    @(posedge pclk);
    cd_pin <= 1'b1;
    cyc(6);
    chk({32'h0, charge_enable}, 33'h0);
    @(posedge pclk);
    cd_pin <= 1'b0;
    level <= 5'(rnd % 8'd21);
    apb(1, CTRL, 32'h28, 33'h0, 33'h1_0000_0000);
    cyc(4);
    chk({32'h0, charge_enable}, 33'h0);
    cyc(MON + 4);
    apb(0, STAT, 32'h0, {20'h0, level, 8'h00}, 33'h1_0000_1F40);
    apb(1, CTRL, 32'h01, 33'h0, 33'h1_0000_0000);
    apb(0, CTRL, 32'h0, 33'h01, 33'h1_0000_0029);
    cyc(4);
    chk({32'h0, charge_enable}, 33'h1);
    @(posedge pclk);
    cd_pin <= 1'b1;
    cyc(QUIET + 6);
    wait_state(ST_INPUT, 1);
    @(posedge pclk);
    vin_on <= 1'b0;
    cyc(4);
    chk({32'h0, state == ST_STORAGE}, 33'h0);
    wait_state(ST_STORAGE, QUIET + 10);
    cyc(2);
    chk({27'h0, battery_switch_on, sys_enable, inter_node_power_on, host_if_active,
         monitor_load_on, inter_node_pulldown_on}, 33'h1);
    // Button wake: node powered at once, exit only after the wake time.
    @(posedge pclk);
    button_n <= 1'b0;
    cyc(4);
    chk({32'h0, inter_node_power_on}, 33'h1);
    cyc(WAKE1 / 2);
    chk({29'h0, state}, {29'h0, ST_STORAGE});
    cyc(WAKE1);
    @(posedge pclk);
    button_n <= 1'b1;
    wait_state(ST_ACTIVE, 20);
    wait_host();
    @(posedge pclk);
    button_n <= 1'b0;
    cyc(LONG + 6);
    @(posedge pclk);
    button_n <= 1'b1;
    wait_state(ST_STORAGE, QUIET + 12);
    @(posedge pclk);
    vin_on <= 1'b1;
    wait_state(ST_INPUT, 20);
    cyc(10);
    @(posedge pclk);
    vin_on <= 1'b0;
    cyc(QUIET + 12);
    wait_state(ST_ACTIVE, 1);
    // Long press still held when the adapter arrives: storage follows its removal.
    @(posedge pclk);
    button_n <= 1'b0;
    cyc(LONG + 6);
    @(posedge pclk);
    vin_on <= 1'b1;
    wait_state(ST_INPUT, 20);
    cyc(4);
    @(posedge pclk);
    button_n <= 1'b1;
    cyc(4);
    @(posedge pclk);
    vin_on <= 1'b0;
    wait_state(ST_STORAGE, QUIET + 16);
    @(posedge pclk);
    vin_on <= 1'b1;
    wait_state(ST_INPUT, 20);
    @(posedge pclk);
    vin_on <= 1'b0;
    wait_state(ST_ACTIVE, 20);
    // High impedance with the output enabled beforehand; the bus locks.
    wait_host();
    rnd = lfsr(rnd);
    @(posedge pclk);
    level <= 5'(rnd % 8'd21);
    apb(1, CTRL, 32'h12, 33'h0, 33'h1_0000_0000);
    wait_state(ST_HIZ, MON + 20);
    chk({32'h0, ldo_enable}, 33'h1);
    apb(0, STAT, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    @(posedge pclk);
    cd_pin <= 1'b0;
    cyc(6);
    @(posedge pclk);
    cd_pin <= 1'b1;
    wait_state(ST_ACTIVE, 20);
    wait_host();
    apb(0, STAT, 32'h0, {20'h0, level, 8'h24}, 33'h1_0000_1F3F);
    // The load-switch input alone enables the output once the bit is cleared.
    apb(1, CTRL, 32'h00, 33'h0, 33'h1_0000_0000);
    cyc(2);
    chk({32'h0, ldo_enable}, 33'h0);
    @(posedge pclk);
    lsw <= 1'b1;
    cyc(4);
    chk({32'h0, ldo_enable}, 33'h1);
    chk({32'h0, exp_q.size() == 0}, 33'h1);
    cyc(2);
    print_verdict();
  end
endmodule
`default_nettype wire
